// [src/power_mode_control.sv]
`timescale 1ns/100ps
module power_mode_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic enabled_irq,
  input wire logic port_mismatch,
  input wire logic comparator_low,
  input wire logic timer3_overflow,
  input wire logic cap_sense_greater,
  input wire logic watchdog_enable,
  output logic core_halt,
  output logic core_reset_vector,
  output logic int_osc_run,
  output logic periph_clk_run,
  output logic irq_timer_enable,
  output logic missing_clk_enable,
  output logic watchdog_run,
  output logic cap_sense_access_ok
);

  // ==========================================================================
  // State
  // ==========================================================================
  // Wake pins are asynchronous to clk, so they pass two flip-flops first.
  typedef struct packed {
    logic [7:0] power_control_reg;
    logic [7:0] internal_osc_control_reg;
    logic idle_pending;
    power_mode_pkg::power_mode_t mode;
    logic [3:0] wake_s1;
    logic [3:0] wake_s2;
    logic [1:0] cap_hold;
    logic [7:0] rdata;
    logic halt;
    logic rst_vec;
    logic osc_run;
    logic pclk_run;
    logic irq_en;
    logic wdt_run;
    logic cap_ok;
    logic mcd_on;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  localparam logic [1:0] hold_cycles =
    2'(power_mode_pkg::cap_wake_hold_cycles);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rdata = 8'h00;
    nxt_cur.wake_s1 = {cap_sense_greater, timer3_overflow, comparator_low,
      port_mismatch};
    nxt_cur.wake_s2 = cur_ff.wake_s1;

    // Register writes; only honoured while the core runs.
    if (reg_write && cur_ff.mode == power_mode_pkg::mode_run) begin
      if (reg_addr == power_mode_pkg::power_control_addr) begin
        nxt_cur.power_control_reg = reg_wdata;
        if (reg_wdata[power_mode_pkg::idle_bit]) begin
          nxt_cur.idle_pending = 1'b1;
        end
      end else if (reg_addr == power_mode_pkg::internal_osc_control_addr)
      begin
        nxt_cur.internal_osc_control_reg = reg_wdata;
      end
    end

    // Read port: data valid in the cycle after the strobe.
    if (reg_read) begin
      if (reg_addr == power_mode_pkg::power_control_addr) begin
        nxt_cur.rdata = cur_ff.power_control_reg;
      end else if (reg_addr == power_mode_pkg::internal_osc_control_addr)
      begin
        nxt_cur.rdata = cur_ff.internal_osc_control_reg;
      end else if (reg_addr == power_mode_pkg::mode_status_addr) begin
        nxt_cur.rdata = {6'h00, cur_ff.mode};
      end else begin
        nxt_cur.rdata = 8'h00;
      end
    end

    nxt_cur.rst_vec = 1'b0;
    if (cur_ff.cap_hold != 2'h0) begin
      nxt_cur.cap_hold = cur_ff.cap_hold - 2'h1;
    end

    case (cur_ff.mode)
      power_mode_pkg::mode_run: begin
        // Idle entry waits for the setting instruction to retire; stop and suspend entry do not.
        if (cur_ff.power_control_reg[power_mode_pkg::stop_bit]) begin
          nxt_cur.mode = power_mode_pkg::mode_stop;
        end else if (cur_ff.internal_osc_control_reg[
            power_mode_pkg::suspend_bit]) begin
          nxt_cur.mode = power_mode_pkg::mode_suspend;
        end else if (cur_ff.idle_pending && instr_done) begin
          nxt_cur.mode = power_mode_pkg::mode_idle;
          nxt_cur.idle_pending = 1'b0;
        end
      end
      power_mode_pkg::mode_idle: begin
        // Registers stay untouched here, except the idle bit cleared on exit, so state is retained.
        if (enabled_irq) begin
          nxt_cur.power_control_reg[power_mode_pkg::idle_bit] = 1'b0;
          // The core resumes its saved program counter.
          nxt_cur.mode = power_mode_pkg::mode_run;
        end
      end
      power_mode_pkg::mode_stop: begin
        // No exit but reset: the clocks interrupts need are stopped.
        nxt_cur.mode = power_mode_pkg::mode_stop;
      end
      power_mode_pkg::mode_suspend: begin
        if (|cur_ff.wake_s2) begin
          nxt_cur.internal_osc_control_reg[power_mode_pkg::suspend_bit] =
            1'b0;
          nxt_cur.mode = power_mode_pkg::mode_run;
          if (cur_ff.wake_s2[3]) begin
            nxt_cur.cap_hold = hold_cycles;
          end
        end
      end
      default: begin
        nxt_cur.mode = power_mode_pkg::mode_run;
      end
    endcase

    nxt_cur.halt = nxt_cur.mode != power_mode_pkg::mode_run;
    nxt_cur.osc_run = nxt_cur.mode == power_mode_pkg::mode_run ||
      nxt_cur.mode == power_mode_pkg::mode_idle;
    nxt_cur.pclk_run = nxt_cur.osc_run;
    nxt_cur.irq_en = nxt_cur.osc_run;
    nxt_cur.wdt_run = watchdog_enable && nxt_cur.osc_run;
    nxt_cur.cap_ok = nxt_cur.cap_hold == 2'h0;
    // The missing-clock detector is never gated by any mode.
    nxt_cur.mcd_on = 1'b1;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Any reset ends every mode and sends the core to address zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.power_control_reg <= power_mode_pkg::power_control_rst;
      cur_ff.internal_osc_control_reg <=
        power_mode_pkg::internal_osc_control_rst;
      cur_ff.mode <= power_mode_pkg::mode_run;
      cur_ff.rst_vec <= 1'b1;
      cur_ff.osc_run <= 1'b1;
      cur_ff.pclk_run <= 1'b1;
      cur_ff.irq_en <= 1'b1;
      cur_ff.cap_ok <= 1'b1;
      cur_ff.mcd_on <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign core_halt = cur_ff.halt;
  assign core_reset_vector = cur_ff.rst_vec;
  assign int_osc_run = cur_ff.osc_run;
  assign periph_clk_run = cur_ff.pclk_run;
  assign irq_timer_enable = cur_ff.irq_en;
  assign missing_clk_enable = cur_ff.mcd_on;
  assign watchdog_run = cur_ff.wdt_run;
  assign cap_sense_access_ok = cur_ff.cap_ok;

endmodule : power_mode_control

// [shared/power_mode_pkg.sv]
package power_mode_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] power_control_addr = 8'h00;
  localparam logic [7:0] internal_osc_control_addr = 8'h04;
  localparam logic [7:0] mode_status_addr = 8'h08;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int idle_bit = 0;
  localparam int stop_bit = 1;
  localparam int suspend_bit = 5;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] power_control_rst = 8'h00;
  localparam logic [7:0] internal_osc_control_rst = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int cap_wake_hold_cycles = 2;

  // ==========================================================================
  // Modes
  // ==========================================================================
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_idle = 2'b01,
    mode_stop = 2'b10,
    mode_suspend = 2'b11
  } power_mode_t;

endpackage : power_mode_pkg

// [dv/power_mode_control_checker.sv]
`timescale 1ns/100ps
module power_mode_control_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic enabled_irq,
  input wire logic core_halt,
  input wire logic core_reset_vector,
  input wire logic int_osc_run,
  input wire logic periph_clk_run,
  input wire logic irq_timer_enable,
  input wire logic missing_clk_enable,
  input wire logic cap_sense_access_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_pclk_follows_osc: assert property (periph_clk_run == int_osc_run)
    else $error("peripheral clock differs from oscillator");
  a_timers_follow_osc: assert property (irq_timer_enable == int_osc_run)
    else $error("timer enable differs from oscillator");
  a_missing_clk_on: assert property (missing_clk_enable)
    else $error("missing clock detector off");
  a_run_keeps_osc: assert property (!core_halt |-> int_osc_run)
    else $error("oscillator stopped while running");
  a_irq_ends_idle: assert property
    (core_halt && int_osc_run && enabled_irq |-> ##[1:3] !core_halt)
    else $error("interrupt did not end idle");
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_vector_short: assert property (core_reset_vector |-> $past(reset))
    else $error("reset vector held too long");
  a_cap_wait_two: assert property
    ($fell(cap_sense_access_ok) |-> !cap_sense_access_ok[*2]
      ##1 cap_sense_access_ok)
    else $error("cap sense access window wrong");
endmodule : power_mode_control_checker
bind power_mode_control power_mode_control_checker
  power_mode_control_checker_i (.clk(clk), .reset(reset),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .enabled_irq(enabled_irq),
  .core_halt(core_halt), .core_reset_vector(core_reset_vector),
  .int_osc_run(int_osc_run), .periph_clk_run(periph_clk_run),
  .irq_timer_enable(irq_timer_enable),
  .missing_clk_enable(missing_clk_enable),
  .cap_sense_access_ok(cap_sense_access_ok));

// [dv/core_model.sv]
`timescale 1ns/100ps
module core_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic irq_req,
  output logic instr_done,
  output logic enabled_irq
);
  // Every write retires one cycle after its strobe; a multibyte
  // instruction always follows, so no idle entry is ever lost.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_done <= 1'b0;
      enabled_irq <= 1'b0;
    end else begin
      instr_done <= reg_write;
      enabled_irq <= irq_req;
    end
  end
endmodule : core_model

// [dv/tb_power_mode_control.sv]
`timescale 1ns/100ps
module tb_power_mode_control;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, irq_req = 0;
  logic wdt_en = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] wake = 4'h0;
  logic instr_done, enabled_irq, core_halt, core_reset_vector, osc;
  logic pclk, irq_tmr, mcd, wdt_run, cap_ok;
  int n_mismatch = 0, checks = 0;
  always #12.5 clk = ~clk;
  core_model core_model_i (.clk(clk), .reset(reset), .reg_write(reg_write),
    .irq_req(irq_req), .instr_done(instr_done), .enabled_irq(enabled_irq));
  power_mode_control power_mode_control_i (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_done(instr_done),
    .enabled_irq(enabled_irq), .port_mismatch(wake[0]),
    .comparator_low(wake[1]), .timer3_overflow(wake[2]),
    .cap_sense_greater(wake[3]), .watchdog_enable(wdt_en),
    .core_halt(core_halt), .core_reset_vector(core_reset_vector),
    .int_osc_run(osc), .periph_clk_run(pclk), .irq_timer_enable(irq_tmr),
    .missing_clk_enable(mcd), .watchdog_run(wdt_run),
    .cap_sense_access_ok(cap_ok));
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask : rd
  // Wake inputs pass two sync flops, so waits are bounded, never fixed.
  task hold(input logic v);
    #1;
    for (int i = 0; i < 40 && core_halt !== v; i++) #25;
    cmp({7'h00, core_halt}, {7'h00, v});
  endtask : hold
  task end_sim;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #100us;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1 cmp({7'h00, core_reset_vector}, 8'h01);
    rd(power_mode_pkg::power_control_addr, 8'h00);
    rd(power_mode_pkg::internal_osc_control_addr, 8'h00);
    rd(8'h10, 8'h00);
    $display("test reset done");
    wr(power_mode_pkg::power_control_addr, 8'h01);
    hold(1'b1);
    cmp({5'h00, osc, pclk, wdt_run}, 8'h07);
    rd(power_mode_pkg::mode_status_addr, 8'h01);
    wr(power_mode_pkg::power_control_addr, 8'h02);
    @(posedge clk) irq_req <= 1'b1;
    hold(1'b0);
    @(posedge clk) irq_req <= 1'b0;
    rd(power_mode_pkg::power_control_addr, 8'h00);
    rd(power_mode_pkg::mode_status_addr, 8'h00);
    $display("test idle done");
    @(posedge clk) wdt_en <= 1'b0;
    wr(power_mode_pkg::power_control_addr, 8'h01);
    hold(1'b1);
    cmp({7'h00, wdt_run}, 8'h00);
    @(posedge clk) irq_req <= 1'b1;
    hold(1'b0);
    @(posedge clk) irq_req <= 1'b0;
    wdt_en <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({7'h00, wdt_run}, 8'h01);
    $display("test watchdog done");
    for (int k = 0; k < 4; k++) begin
      wr(power_mode_pkg::internal_osc_control_addr, 8'h20);
      hold(1'b1);
      cmp({7'h00, osc}, 8'h00);
      rd(power_mode_pkg::mode_status_addr, 8'h03);
      @(posedge clk) wake[k] <= 1'b1;
      hold(1'b0);
      @(posedge clk) wake <= 4'h0;
      rd(power_mode_pkg::internal_osc_control_addr, 8'h00);
      repeat (4) @(posedge clk);
    end
    $display("test suspend done");
    wr(power_mode_pkg::power_control_addr, 8'h02);
    hold(1'b1);
    cmp({4'h0, osc, irq_tmr, wdt_run, mcd}, 8'h01);
    rd(power_mode_pkg::mode_status_addr, 8'h02);
    @(posedge clk) irq_req <= 1'b1;
    wake <= 4'hf;
    repeat (20) @(posedge clk);
    #1 cmp({7'h00, core_halt}, 8'h01);
    @(posedge clk) reset <= 1'b1;
    irq_req <= 1'b0;
    wake <= 4'h0;
    #1 cmp({6'h00, core_halt, core_reset_vector}, 8'h01);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(power_mode_pkg::mode_status_addr, 8'h00);
    $display("test stop done");
    end_sim;
  end
endmodule : tb_power_mode_control
